//--- rtl/bsp_pkg.sv
// shared constants and types of the burst-of-four double-rate memory port
// assumes a single clk_i domain that oversamples the forwarded clock pair
`default_nettype none

package bsp_pkg;

  // ----------------------------------------------------------------
  // burst and pipeline geometry
  // ----------------------------------------------------------------
  localparam int BSP_BURST_LEN = 4;
  localparam int BSP_BEAT_W = 2;
  localparam int BSP_BYTE_W = 9;
  localparam int BSP_PIPE_DEPTH = 8;
  localparam int BSP_FIFO_DEPTH = 2;

  // ----------------------------------------------------------------
  // latencies, counted in half cycles of the input clock pair
  // ----------------------------------------------------------------
  localparam int BSP_RD_LAT_DLL_ON = 5;
  localparam int BSP_RD_LAT_DLL_OFF = 2;
  localparam int BSP_WR_LAT = 2;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int BSP_ADDR_W = 19;
  localparam int BSP_DATA_W_NARROW = 18;
  localparam int BSP_DATA_W_WIDE = 36;
  localparam int BSP_LOCK_K_CYCLES = 2048;
  localparam int BSP_CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // delay-locked loop state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSP_DLL_OFF,
    BSP_DLL_LOCKING,
    BSP_DLL_LOCKED
  } bsp_dll_t;

endpackage : bsp_pkg

`default_nettype wire

//--- rtl/bsp_mem_if.sv
// carrier between the port logic and its storage array
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none

interface bsp_mem_if #(
  parameter int AW = 21,
  parameter int DW = 18,
  parameter int NB = 2
);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [NB-1:0] be;
  logic [DW-1:0] rdata;

  modport ctrl (output en, output we, output addr, output wdata, output be,
                input rdata);
  modport mem (input en, input we, input addr, input wdata, input be,
               output rdata);
endinterface : bsp_mem_if

`default_nettype wire

//--- rtl/bsp_sram_array.sv
// single-port storage array with byte enables and registered read data
// assumes one access per cycle, chosen by the port logic
`timescale 1ns/1ns
`default_nettype none

module bsp_sram_array #(
  parameter int AW = 21,
  parameter int DW = 18,
  parameter int NB = 2
)(
  input wire logic clk_i,
  bsp_mem_if.mem bus
);
  import bsp_pkg::*;

  // byte enables split the word into whole bytes only
  if (DW != NB * BSP_BYTE_W) begin : g_dw
    $error("data width must be a whole number of bytes");
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // the array itself is too big for the state struct
  logic [DW-1:0] arr [0:(2**AW)-1];

  always_ff @(posedge clk_i) begin
    if (bus.en && bus.we) begin
      for (int b = 0; b < NB; b++) begin
        if (bus.be[b]) begin
          arr[bus.addr][b*BSP_BYTE_W +: BSP_BYTE_W] <=
            bus.wdata[b*BSP_BYTE_W +: BSP_BYTE_W];
        end
      end
    end
    if (bus.en && !bus.we) begin
      bus.rdata <= arr[bus.addr];
    end
  end

endmodule : bsp_sram_array

`default_nettype wire

//--- rtl/bsp_burst4_port.sv
// pin-level logic of a burst-of-four double-rate memory with split buses
// assumes clk_i oversamples the input clock pair at least six to one
`timescale 1ns/1ns
`default_nettype none

module bsp_burst4_port #(
  parameter int ADDR_W = bsp_pkg::BSP_ADDR_W,
  parameter int DATA_W = bsp_pkg::BSP_DATA_W_NARROW,
  parameter int LOCK_K_CYCLES = bsp_pkg::BSP_LOCK_K_CYCLES,
  parameter int FIFO_DEPTH = bsp_pkg::BSP_FIFO_DEPTH
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  input wire logic [ADDR_W-1:0] sync_address_i,
  input wire logic [DATA_W-1:0] write_data_in_i,
  input wire logic [DATA_W/bsp_pkg::BSP_BYTE_W-1:0] byte_write_n_i,
  input wire logic dll_off_n_i,
  output logic [DATA_W-1:0] read_data_out_o,
  output logic output_valid_o,
  output logic echo_clock_o,
  output logic echo_clock_inv_o,
  output logic dll_locked_o,
  output logic write_stall_o
);
  import bsp_pkg::*;

  // ----------------------------------------------------------------
  // derived sizes and pin vector layout
  // ----------------------------------------------------------------
  localparam int NB = DATA_W / BSP_BYTE_W;
  localparam int MEM_AW = ADDR_W + BSP_BEAT_W;
  localparam int ENT_W = MEM_AW + DATA_W + NB;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int LOCK_W = $clog2(LOCK_K_CYCLES + 1);
  localparam int P_K = 0;
  localparam int P_KN = 1;
  localparam int P_RD = 2;
  localparam int P_WR = 3;
  localparam int P_DLL = 4;
  localparam int P_ADDR = 5;
  localparam int P_DATA = P_ADDR + ADDR_W;
  localparam int P_BW = P_DATA + DATA_W;
  localparam int SYNC_W = P_BW + NB;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_K_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (DATA_W != BSP_DATA_W_NARROW && DATA_W != BSP_DATA_W_WIDE) begin : g_bw
    $error("data width must be the narrow or the wide configuration");
  end
  if (FIFO_DEPTH < 1 || LOCK_K_CYCLES < 1 || ADDR_W < 1) begin : g_bp
    $error("fifo depth, lock count and address width must be positive");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] f;
    logic [BSP_PIPE_DEPTH-1:0] rtok;
    logic [BSP_PIPE_DEPTH-1:0] wtok;
    logic [BSP_PIPE_DEPTH-1:0][ADDR_W-1:0] raddr;
    logic [BSP_PIPE_DEPTH-1:0][ADDR_W-1:0] waddr;
    bsp_dll_t dll;
    logic [LOCK_W-1:0] lock_cnt;
    logic fetch;
    logic rd_pend;
    logic beat_vld;
    logic [DATA_W-1:0] beat_data;
    logic [FIFO_DEPTH-1:0][ENT_W-1:0] fq;
    logic [CNT_W-1:0] fcnt;
    logic [DATA_W-1:0] q;
    logic qv;
    logic cq;
    logic cqn;
    logic locked;
    logic stall;
  } bsp_state_t;

  bsp_state_t r;
  bsp_state_t next_r;

  bsp_mem_if #(.AW(MEM_AW), .DW(DATA_W), .NB(NB)) mem_bus ();

  bsp_sram_array #(.AW(MEM_AW), .DW(DATA_W), .NB(NB)) u_array (
    .clk_i(clk_i),
    .bus(mem_bus.mem)
  );

  logic [SYNC_W-1:0] pins;
  assign pins = {byte_write_n_i, write_data_in_i, sync_address_i,
                 dll_off_n_i, write_n_i, read_n_i, k_n_i, k_i};

  // finds the beat of a burst whose token sits at base..base+3
  function automatic logic [BSP_BEAT_W:0] bsp_pend(
    input logic [BSP_PIPE_DEPTH-1:0] tok,
    input int base
  );
    logic [BSP_BEAT_W:0] res;
    res = '0;
    for (int i = 0; i < BSP_BURST_LEN; i++) begin
      if (tok[base + i]) begin
        res = {1'b1, BSP_BEAT_W'(i)};
      end
    end
    return res;
  endfunction : bsp_pend

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] agree;
  logic k_rise;
  logic kn_rise;
  logic rd_cmd;
  logic wr_cmd;
  logic push;
  logic pop;
  int rbase;
  logic [BSP_BEAT_W:0] wp;
  logic [BSP_BEAT_W:0] rp;
  logic [ENT_W-1:0] ent;
  logic [ENT_W-1:0] head;
  logic [CNT_W-1:0] slot;

  always_comb begin
    next_r = r;
    mem_bus.en = 1'b0;
    mem_bus.we = 1'b0;
    mem_bus.addr = '0;
    mem_bus.wdata = '0;
    mem_bus.be = '0;
    push = 1'b0;
    pop = 1'b0;
    ent = '0;
    wp = '0;
    rp = '0;
    // pins: three stages, a level counts once stages two and three agree
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    agree = ~(r.s2 ^ r.s3);
    next_r.f = (agree & r.s3) | (~agree & r.f);
    k_rise = next_r.f[P_K] & ~r.f[P_K];
    kn_rise = next_r.f[P_KN] & ~r.f[P_KN];
    rd_cmd = k_rise & ~next_r.f[P_RD];
    wr_cmd = k_rise & ~next_r.f[P_WR];
    // echo clocks follow the filtered pair, so they never stop
    next_r.cq = next_r.f[P_K];
    next_r.cqn = next_r.f[P_KN];

    // loop control
    if (!next_r.f[P_DLL]) begin
      next_r.dll = BSP_DLL_OFF;
      next_r.lock_cnt = '0;
    end else begin
      case (r.dll)
        BSP_DLL_OFF: next_r.dll = BSP_DLL_LOCKING;
        BSP_DLL_LOCKING: begin
          if (k_rise) begin
            if (r.lock_cnt == LOCK_LAST) begin
              next_r.dll = BSP_DLL_LOCKED;
            end else begin
              next_r.lock_cnt = r.lock_cnt + 1'b1;
            end
          end
        end
        default: next_r.dll = r.dll;
      endcase
    end
    next_r.locked = (next_r.dll == BSP_DLL_LOCKED);
    // still locking counts as off: the short latency is the safe one
    rbase = (r.dll == BSP_DLL_LOCKED) ? BSP_RD_LAT_DLL_ON - 1
                                      : BSP_RD_LAT_DLL_OFF - 1;

    // every half-cycle edge advances both burst pipelines
    next_r.fetch = k_rise | kn_rise;
    if (k_rise | kn_rise) begin
      wp = bsp_pend(r.wtok, BSP_WR_LAT - 1);
      if (wp[BSP_BEAT_W]) begin
        push = 1'b1;
        ent = {r.waddr[BSP_WR_LAT - 1 + int'(wp[BSP_BEAT_W-1:0])],
               wp[BSP_BEAT_W-1:0], next_r.f[P_DATA +: DATA_W],
               ~next_r.f[P_BW +: NB]};
      end
      next_r.q = r.beat_vld ? r.beat_data : '0;
      next_r.qv = r.beat_vld;
      next_r.beat_vld = 1'b0;
      next_r.rtok = {r.rtok[BSP_PIPE_DEPTH-2:0], rd_cmd};
      next_r.wtok = {r.wtok[BSP_PIPE_DEPTH-2:0], wr_cmd};
      next_r.raddr = {r.raddr[BSP_PIPE_DEPTH-2:0],
                      rd_cmd ? next_r.f[P_ADDR +: ADDR_W] : ADDR_W'(0)};
      next_r.waddr = {r.waddr[BSP_PIPE_DEPTH-2:0],
                      wr_cmd ? next_r.f[P_ADDR +: ADDR_W] : ADDR_W'(0)};
    end

    // prefetch the beat due at the coming edge; reads beat writes
    if (r.fetch) begin
      rp = bsp_pend(r.rtok, rbase);
      if (rp[BSP_BEAT_W]) begin
        mem_bus.en = 1'b1;
        mem_bus.addr = {r.raddr[rbase + int'(rp[BSP_BEAT_W-1:0])],
                        rp[BSP_BEAT_W-1:0]};
      end
    end
    next_r.rd_pend = mem_bus.en;
    if (r.rd_pend) begin
      next_r.beat_data = mem_bus.rdata;
      next_r.beat_vld = 1'b1;
    end

    // write buffer drains into the array whenever no read needs it
    head = r.fq[0];
    if (!mem_bus.en && r.fcnt != '0) begin
      pop = 1'b1;
      mem_bus.en = 1'b1;
      mem_bus.we = 1'b1;
      mem_bus.addr = head[ENT_W-1 -: MEM_AW];
      mem_bus.wdata = head[NB +: DATA_W];
      mem_bus.be = head[NB-1:0];
    end
    if (pop) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        next_r.fq[i] = r.fq[i + 1];
      end
      next_r.fq[FIFO_DEPTH-1] = '0;
    end
    slot = r.fcnt - CNT_W'(pop);
    // a push into a full buffer is lost; stall shows it can happen
    if (push && slot != CNT_FULL) begin
      next_r.fq[slot] = ent;
    end
    next_r.fcnt = slot + CNT_W'(push && slot != CNT_FULL);
    next_r.stall = (next_r.fcnt == CNT_FULL);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign read_data_out_o = r.q;
  assign output_valid_o = r.qv;
  assign echo_clock_o = r.cq;
  assign echo_clock_inv_o = r.cqn;
  assign dll_locked_o = r.locked;
  assign write_stall_o = r.stall;

endmodule : bsp_burst4_port

`default_nettype wire

//--- bench/bsp_port_sva.sv
// checker of the port's read outputs and loop status
// bound onto bsp_burst4_port; one clk_i domain
`timescale 1ns/1ns
`default_nettype none
module bsp_port_sva #(
  parameter int DATA_W = 18,
  parameter int LOCK_K_CYCLES = 4
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dll_off_n_i,
  input wire logic [DATA_W-1:0] read_data_out_o,
  input wire logic output_valid_o,
  input wire logic echo_clock_o,
  input wire logic echo_clock_inv_o,
  input wire logic dll_locked_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  int kcnt;
  int bcnt;
  // ----------------------------------------
  // k rises while enabled, beats in a valid run
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    kcnt <= (rst_i || !dll_off_n_i) ? 0 : kcnt + int'($rose(echo_clock_o));
    bcnt <= (rst_i || !output_valid_o) ? 0 :
      bcnt + int'($rose(echo_clock_o) || $rose(echo_clock_inv_o));
  end
  sequence echo_edge_s;
    $rose(echo_clock_o) || $rose(echo_clock_inv_o);
  endsequence
  zero_data_a:
    assert property (!output_valid_o |-> read_data_out_o == '0)
    else $error("read data outside a beat");
  echo_toggle_a:
    assert property ($rose(echo_clock_o) |-> ##[4:8] $fell(echo_clock_o))
    else $error("echo clock stuck");
  echo_pair_a:
    assert property ($rose(echo_clock_o) |-> ##[4:8] $rose(echo_clock_inv_o))
    else $error("inverted echo stuck");
  valid_edge_a:
    assert property ($rose(output_valid_o) |-> echo_edge_s)
    else $error("valid off echo edge");
  data_edge_a:
    assert property ($changed(read_data_out_o) |-> echo_edge_s)
    else $error("data off echo edge");
  burst_four_a:
    assert property ($fell(output_valid_o) |-> bcnt != 0 && bcnt % 4 == 0)
    else $error("valid run not whole bursts");
  dll_drop_a:
    assert property (!dll_off_n_i |-> ##[1:6] !dll_locked_o)
    else $error("lock kept while disabled");
  lock_time_a:
    assert property ($rose(dll_locked_o) |-> kcnt >= LOCK_K_CYCLES - 1)
    else $error("lock too early");
endmodule : bsp_port_sva
bind bsp_burst4_port bsp_port_sva #(
  .DATA_W(DATA_W),
  .LOCK_K_CYCLES(LOCK_K_CYCLES)
) i_sva (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .dll_off_n_i(dll_off_n_i),
  .read_data_out_o(read_data_out_o),
  .output_valid_o(output_valid_o),
  .echo_clock_o(echo_clock_o),
  .echo_clock_inv_o(echo_clock_inv_o),
  .dll_locked_o(dll_locked_o)
);
`default_nettype wire

//--- bench/bsp_ctrl_model.sv
// controller model: clock pair, commands and write beats
// assumes the bench calls one task at a time
`timescale 1ns/1ns
`default_nettype none
module bsp_ctrl_model #(
  parameter int AW = 19,
  parameter int DW = 18
)(
  output logic k_o,
  output logic k_n_o,
  output logic read_n_o,
  output logic write_n_o,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] wdata_o,
  output logic [DW/9-1:0] bw_n_o
);
  // -------------------------------
  // free-running pair, 125 ns period
  // -------------------------------
  initial begin
    k_o = 1'b0;
    k_n_o = 1'b1;
    read_n_o = 1'b1;
    write_n_o = 1'b1;
    addr_o = '0;
    wdata_o = '0;
    bw_n_o = '1;
    forever begin
      #63 k_o = 1'b1;
      k_n_o = 1'b0;
      #62 k_o = 1'b0;
      k_n_o = 1'b1;
    end
  end
  // pins move mid half-cycle, so each edge sees settled values
  task automatic cmd(input logic rd, input logic wr, input logic [AW-1:0] a);
    @(posedge k_n_o);
    #31 read_n_o = !rd;
    write_n_o = !wr;
    addr_o = a;
    @(posedge k_o);
    #31 read_n_o = 1'b1;
    write_n_o = 1'b1;
    addr_o = ~a;
  endtask : cmd
  task automatic wr(input logic [AW-1:0] a, input logic [3:0][DW-1:0] d,
                    input logic [3:0][DW/9-1:0] m);
    cmd(1'b0, 1'b1, a);
    for (int i = 0; i < 5; i++) begin
      @(posedge k_o or posedge k_n_o);
      #31 wdata_o = (i < 4) ? d[i] : ~d[3];
      bw_n_o = (i < 4) ? m[i] : '1;
    end
  endtask : wr
endmodule : bsp_ctrl_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench of the burst-of-four port
// assumes the controller model owns every link pin
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import bsp_pkg::*;
  localparam int AW = BSP_ADDR_W;
  localparam int DW = BSP_DATA_W_NARROW;
  localparam int NB = DW / BSP_BYTE_W;
  localparam int LK = 4;
  logic clk_i;
  logic rst_i = 1'b1;
  logic dll_off_n = 1'b0;
  logic k, k_n, rd_n, wr_n, valid, echo, echo_inv, locked, stall;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [NB-1:0] bw_n;
  logic vp = 1'b0;
  logic ep = 1'b0;
  logic enp = 1'b0;
  int mismatches = 0;
  int comparisons = 0;
  time t_first;
  logic [DW-1:0] beats[$];
  logic [DW-1:0] mem[logic [AW+1:0]];
  bsp_ctrl_model #(.AW(AW), .DW(DW)) i_ctrl (.k_o(k), .k_n_o(k_n),
    .read_n_o(rd_n), .write_n_o(wr_n), .addr_o(addr), .wdata_o(wdata),
    .bw_n_o(bw_n));
  bsp_burst4_port #(.LOCK_K_CYCLES(LK)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .k_i(k), .k_n_i(k_n), .read_n_i(rd_n),
    .write_n_i(wr_n), .sync_address_i(addr), .write_data_in_i(wdata),
    .byte_write_n_i(bw_n), .dll_off_n_i(dll_off_n),
    .read_data_out_o(rdata), .output_valid_o(valid), .echo_clock_o(echo),
    .echo_clock_inv_o(echo_inv), .dll_locked_o(locked),
    .write_stall_o(stall));
  // ----------------------------
  // clock, beat capture, checks
  // ----------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // one beat per echo edge while valid stands
  always @(posedge clk_i) begin
    if (valid === 1'b1 && (!vp || echo !== ep || echo_inv !== enp)) begin
      if (beats.size() == 0) t_first = $time;
      beats.push_back(rdata);
    end
    vp <= valid;
    ep <= echo;
    enp <= echo_inv;
  end
  task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk_flag
  task automatic write(input logic [AW-1:0] a, input logic [3:0][DW-1:0] d,
                       input logic [3:0][NB-1:0] m);
    beats.delete();
    i_ctrl.wr(a, d, m);
    for (int i = 0; i < 4; i++)
      for (int b = 0; b < NB; b++)
        if (!m[i][b]) mem[{a, 2'(i)}][9*b +: 9] = d[i][9*b +: 9];
    chk_flag(stall, 1'b0);
    chk_flag(beats.size() == 0, 1'b1);
  endtask : write
  // n reads every other k rise; slow picks the 2.5 cycle latency
  task automatic read(input logic [AW-1:0] a, input int n, input bit slow);
    time t0;
    time lo;
    lo = slow ? 312 : 125;
    beats.delete();
    for (int r = 0; r < n; r++) begin
      // skip one k rise: back-to-back bursts would overlap otherwise
      if (r > 0) @(posedge k);
      i_ctrl.cmd(1'b1, 1'b0, a + AW'(r));
      if (r == 0) t0 = $time - 31;
    end
    for (int w = 0; w < 100 && beats.size() < 4 * n; w++) @(posedge clk_i);
    chk_flag(beats.size() == 4 * n, 1'b1);
    for (int i = 0; i < beats.size(); i++)
      chk_word(beats[i], mem[{a + AW'(i / 4), 2'(i % 4)}]);
    chk_flag(t_first - t0 >= lo && t_first - t0 < lo + 62, 1'b1);
  endtask : read
  // loop enabled: not locked early, locked once the count has run
  task automatic lock_up;
    @(posedge clk_i);
    #1 dll_off_n = 1'b1;
    repeat (2) @(posedge k);
    chk_flag(locked, 1'b0);
    repeat (LK + 2) @(posedge k);
    chk_flag(locked, 1'b1);
  endtask : lock_up
  // loop disabled: lock must be gone within a couple of k periods
  task automatic lock_drop;
    @(posedge clk_i);
    #1 dll_off_n = 1'b0;
    repeat (2) @(posedge k);
    chk_flag(locked, 1'b0);
  endtask : lock_drop
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    logic [3:0][DW-1:0] d;
    d = {18'h3_0f0f, 18'h2_1234, 18'h1_ffff, 18'h0_5a5a};
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge k);
    write(19'h0_0040, d, '0);
    write(19'h0_0041, ~d, '0);
    read(19'h0_0040, 1, 1'b0);
    write(19'h0_0040, {4{18'h2_aaaa}}, {2'h0, 2'h1, 2'h2, 2'h3});
    read(19'h0_0040, 2, 1'b0);
    lock_up();
    read(19'h0_0040, 2, 1'b1);
    lock_drop();
    read(19'h0_0041, 1, 1'b0);
    end_sim();
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
